/* core/aod_pkg.sv */
// Package for the accelerometer output data register block
package aod_pkg;
    localparam int AOD_AW = 8;
    localparam int AOD_DW = 8;
    localparam int AOD_SW = 12;
    localparam int AOD_TW = 8;
    // Register offsets
    localparam logic [7:0] AOD_TEMPERATURE_OUT = 8'h01;
    localparam logic [7:0] AOD_MAGNITUDE_LOW = 8'h02;
    localparam logic [7:0] AOD_MAGNITUDE_HIGH = 8'h03;
    localparam logic [7:0] AOD_ACCEL_X_LOW = 8'h04;
    localparam logic [7:0] AOD_ACCEL_X_HIGH = 8'h05;
    localparam logic [7:0] AOD_ACCEL_Y_LOW = 8'h06;
    localparam logic [7:0] AOD_ACCEL_Y_HIGH = 8'h07;
    localparam logic [7:0] AOD_ACCEL_Z_LOW = 8'h08;
    localparam logic [7:0] AOD_ACCEL_Z_HIGH = 8'h09;
    // Reset values, fills and the magnitude saturation limit
    localparam logic [7:0] AOD_BYTE_ZERO = 8'h00;
    localparam logic [11:0] AOD_WORD_ZERO = 12'h000;
    localparam logic [3:0] AOD_NIB_ZERO = 4'h0;
    localparam logic [11:0] AOD_MAG_MAX = 12'hfff;
    // Acquisition spacing between samples
    localparam int AOD_CLK_HZ = 10_000_000;
    localparam int AOD_SPACING_US = 40;
    localparam int AOD_SPACING_CYC = (AOD_SPACING_US * AOD_CLK_HZ) / 1_000_000;
    localparam int AOD_CNT_W = 10;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        AOD_IDLE = 5'h01,
        AOD_TEMP = 5'h02,
        AOD_AX = 5'h04,
        AOD_AY = 5'h08,
        AOD_AZ = 5'h10
    } aod_state_t;
endpackage

/* core/aod_mag_if.sv */
// Interface carrying magnitude requests and results between modules
`timescale 1ns/1ps
interface aod_mag_if;
    logic start;
    logic [11:0] ax;
    logic [11:0] ay;
    logic [11:0] az;
    logic done;
    logic [11:0] mag;
    modport req (output start, output ax, output ay, output az, input done, input mag);
    modport calc (input start, input ax, input ay, input az, output done, output mag);
endinterface

/* core/aod_magnitude.sv */
// Sequential square root of the sum of squared axis values
`timescale 1ns/1ps
module aod_magnitude (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Request and result
    aod_mag_if.calc mag_if
);
    import aod_pkg::*;

    logic [25:0] rem_reg, rem_next;
    logic [12:0] root_reg, root_next;
    logic [13:0] bit_reg, bit_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [11:0] mag_reg, mag_next;

    // Square of a signed axis value
    function automatic logic [23:0] sq(input logic [11:0] v);
        logic [11:0] a;
        a = v[11] ? 12'(-v) : v;
        return 24'(a) * 24'(a);
    endfunction

    // Bitwise integer square root, one result bit per cycle
    always_comb begin
        rem_next = rem_reg;
        root_next = root_reg;
        bit_next = bit_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        mag_next = mag_reg;
        if (mag_if.start) begin
            rem_next = 26'(sq(mag_if.ax)) + 26'(sq(mag_if.ay)) + 26'(sq(mag_if.az));
            root_next = 13'h0000;
            bit_next = 14'h1000;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (rem_reg >= 26'(root_reg + 13'(bit_reg)) * 26'(root_reg + 13'(bit_reg))) begin
                root_next = root_reg + 13'(bit_reg);
            end
            bit_next = bit_reg >> 1;
            if (bit_reg == 14'h0001) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                // Saturate to the 12-bit unsigned range
                if (rem_reg >= 26'(root_reg + 13'h0001) * 26'(root_reg + 13'h0001))
                    mag_next = (root_reg + 13'h0001) > 13'(AOD_MAG_MAX) ? AOD_MAG_MAX
                               : 12'(root_reg + 13'h0001);
                else
                    mag_next = root_reg > 13'(AOD_MAG_MAX) ? AOD_MAG_MAX : root_reg[11:0];
            end
        end
    end

    // Register the root state
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rem_reg <= '0;
            root_reg <= '0;
            bit_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            mag_reg <= AOD_WORD_ZERO;
        end else begin
            rem_reg <= rem_next;
            root_reg <= root_next;
            bit_reg <= bit_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            mag_reg <= mag_next;
        end
    end

    assign mag_if.done = done_reg;
    assign mag_if.mag = mag_reg;
endmodule

/* core/aod_output_regs.sv */
// Output data registers of a 3-axis accelerometer: sample latch, byte order, read port
//
// Summary of operation
// - Temperature is 8-bit two's complement, zero means about 25 degrees C.
// - Temperature register refreshes once each output data rate cycle.
// - Magnitude is computed only while magnitude_enable is one.
// - Reading either magnitude byte clears the data-ready flag.
// - Magnitude bits 7:0 at 02h, bits 11:8 low nibble of 03h, reset zero.
// - Magnitude byte order follows byte_order_select, little-endian after reset.
// - X, Y, Z are 12-bit two's complement at 04h to 09h, X first.
// - Temperature and axes latch together as the data-ready flag sets.
// - Reading any of the six axis bytes clears the data-ready flag.
// - Fast-read burst auto-increment skips the axis high-byte registers; magnitude high byte 03h is still visited.
// - Fast-read returns each axis's upper bits at its low-byte address.
// - Little-endian: bits 7:0 low address, bits 11:8 next with sign fill for axes, zero fill for magnitude.
// - Big-endian: bits 11:4 low address, bits 3:0 upper nibble of next.
// - Temperature then X, Y, Z acquired about 40 us apart, then latched.
// - Axis byte order follows byte_order_select, little-endian after reset.
// - Register reads and writes are refused until boot completes.
`timescale 1ns/1ps
module aod_output_regs #(
    parameter int SPACING_CYC = aod_pkg::AOD_SPACING_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Configuration and status from the rest of the device
    input wire logic boot_done_i,
    input wire logic magnitude_enable_i,
    input wire logic byte_order_select_i,
    input wire logic fast_read_i,
    // Conversion trigger and converter samples
    input wire logic output_data_rate_tick_i,
    input wire logic [aod_pkg::AOD_TW-1:0] temp_sample_i,
    input wire logic [aod_pkg::AOD_SW-1:0] adc_sample_i,
    // Register access port from the serial interface
    input wire logic reg_start_i,
    input wire logic [aod_pkg::AOD_AW-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [aod_pkg::AOD_DW-1:0] reg_wdata_i,
    output logic [aod_pkg::AOD_DW-1:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_refused_o,
    // Data-ready status
    output logic data_ready_flag_o
);
    import aod_pkg::*;

    aod_mag_if mag_if ();

    aod_state_t state_reg, state_next;
    logic [AOD_CNT_W-1:0] cnt_reg, cnt_next;
    logic [AOD_TW-1:0] temp_hold_reg, temp_hold_next;
    logic [AOD_SW-1:0] x_hold_reg, x_hold_next;
    logic [AOD_SW-1:0] y_hold_reg, y_hold_next;
    logic [AOD_SW-1:0] z_hold_reg, z_hold_next;
    logic [AOD_TW-1:0] temp_reg, temp_next;
    logic [AOD_SW-1:0] x_reg, x_next;
    logic [AOD_SW-1:0] y_reg, y_next;
    logic [AOD_SW-1:0] z_reg, z_next;
    logic [AOD_SW-1:0] mag_reg, mag_next;
    logic drdy_reg, drdy_next;
    logic mag_start;
    logic latch;
    logic [AOD_AW-1:0] ptr_reg, ptr_next;
    logic [AOD_DW-1:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic refused_reg, refused_next;
    logic [1:0] boot_sync_reg;
    logic boot_ok;
    logic rd_axis;
    logic rd_mag;
    logic [AOD_AW-1:0] cur_addr;

    // Boot status from another domain passes two flip-flops
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_sync_reg <= 2'h0;
        end else begin
            boot_sync_reg <= {boot_sync_reg[0], boot_done_i};
        end
    end
    assign boot_ok = boot_sync_reg[1];

    // Byte seen at an address for one 12-bit axis word
    function automatic logic [7:0] axis_byte(input logic [11:0] v, input logic hi,
                                             input logic be, input logic fr);
        logic [7:0] b;
        b = AOD_BYTE_ZERO;
        if (fr || be) begin
            // Upper bits first in big-endian and fast-read
            b = hi ? {v[3:0], AOD_NIB_ZERO} : v[11:4];
        end else begin
            // Low bits first, sign fill above bits 11:8
            b = hi ? {{4{v[11]}}, v[11:8]} : v[7:0];
        end
        return b;
    endfunction

    // Next address of a burst, skipping axis high bytes in fast-read
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fr);
        logic [7:0] n;
        n = a + 8'h01;
        // Only even axis addresses jump; Z low goes straight past the block
        if (fr && a >= AOD_ACCEL_X_LOW && a < AOD_ACCEL_Z_HIGH && !a[0])
            n = a + 8'h02;
        return n;
    endfunction

    // Acquisition sequencer: temperature, then X, Y, Z spaced apart
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        temp_hold_next = temp_hold_reg;
        x_hold_next = x_hold_reg;
        y_hold_next = y_hold_reg;
        z_hold_next = z_hold_reg;
        latch = 1'b0;
        // One state per held sample; latch is a single-cycle strobe
        case (state_reg)
            AOD_IDLE: begin
                if (output_data_rate_tick_i) begin
                    temp_hold_next = temp_sample_i;
                    cnt_next = '0;
                    state_next = AOD_TEMP;
                end
            end

            // Temperature held; count one spacing before X
            AOD_TEMP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == AOD_CNT_W'(SPACING_CYC - 1)) begin
                    x_hold_next = adc_sample_i;
                    cnt_next = '0;
                    state_next = AOD_AX;
                end
            end

            // X held; count one spacing before Y
            AOD_AX: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == AOD_CNT_W'(SPACING_CYC - 1)) begin
                    y_hold_next = adc_sample_i;
                    cnt_next = '0;
                    state_next = AOD_AY;
                end
            end

            // Y held; count one spacing before Z
            AOD_AY: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == AOD_CNT_W'(SPACING_CYC - 1)) begin
                    z_hold_next = adc_sample_i;
                    cnt_next = '0;
                    state_next = AOD_AZ;
                end
            end

            // All four held; publish them together in one cycle
            AOD_AZ: begin
                latch = 1'b1;
                state_next = AOD_IDLE;
            end

            // Illegal codes fall back to idle
            default: state_next = AOD_IDLE;
        endcase
    end

    // Magnitude runs on each new sample only when enabled
    assign mag_start = latch && magnitude_enable_i;
    // Hold registers feed the root engine and stay put until the next trigger
    assign mag_if.start = mag_start;
    assign mag_if.ax = x_hold_reg;
    assign mag_if.ay = y_hold_reg;
    assign mag_if.az = z_hold_reg;

    aod_magnitude u_mag (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .mag_if(mag_if)
    );

    // Address in play this cycle: start address or burst pointer
    assign cur_addr = reg_start_i ? reg_addr_i : ptr_reg;
    // Accepted reads of the addresses that clear the ready flag
    assign rd_axis = reg_rd_i && boot_ok && cur_addr >= AOD_ACCEL_X_LOW
                     && cur_addr <= AOD_ACCEL_Z_HIGH;
    assign rd_mag = reg_rd_i && boot_ok && (cur_addr == AOD_MAGNITUDE_LOW
                     || cur_addr == AOD_MAGNITUDE_HIGH);

    // Output registers, data-ready flag and register read port
    always_comb begin
        temp_next = temp_reg;
        x_next = x_reg;
        y_next = y_reg;
        z_next = z_reg;
        mag_next = mag_reg;
        drdy_next = drdy_reg;
        ptr_next = ptr_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        refused_next = 1'b0;
        // Reads clear the flag; a new sample in the same cycle wins
        if (rd_axis || rd_mag)
            drdy_next = 1'b0;

        if (latch) begin
            temp_next = temp_hold_reg;
            x_next = x_hold_reg;
            y_next = y_hold_reg;
            z_next = z_hold_reg;
            drdy_next = 1'b1;
        end

        // Magnitude lands when the root engine finishes, kept when disabled
        if (mag_if.done)
            mag_next = mag_if.mag;

        // Refused accesses leave read data and burst pointer untouched
        if ((reg_rd_i || reg_wr_i) && !boot_ok) begin
            refused_next = 1'b1;
        end else if (reg_wr_i) begin
            // Writes are acknowledged and ignored
            ack_next = 1'b1;
            ptr_next = next_addr(cur_addr, 1'b0);
        end else if (reg_rd_i) begin
            ack_next = 1'b1;
            ptr_next = next_addr(cur_addr, fast_read_i);
            case (cur_addr)
                AOD_TEMPERATURE_OUT: rdata_next = temp_reg;
                // Magnitude bytes honour byte order
                AOD_MAGNITUDE_LOW: rdata_next = byte_order_select_i ? mag_reg[11:4]
                                                                    : mag_reg[7:0];
                AOD_MAGNITUDE_HIGH: rdata_next = byte_order_select_i
                                                 ? {mag_reg[3:0], AOD_NIB_ZERO}
                                                 : {AOD_NIB_ZERO, mag_reg[11:8]};
                // Axis bytes honour byte order
                AOD_ACCEL_X_LOW: rdata_next = axis_byte(x_reg, 1'b0, byte_order_select_i,
                                                        fast_read_i);
                AOD_ACCEL_X_HIGH: rdata_next = axis_byte(x_reg, 1'b1, byte_order_select_i,
                                                         fast_read_i);
                AOD_ACCEL_Y_LOW: rdata_next = axis_byte(y_reg, 1'b0, byte_order_select_i,
                                                        fast_read_i);
                AOD_ACCEL_Y_HIGH: rdata_next = axis_byte(y_reg, 1'b1, byte_order_select_i,
                                                         fast_read_i);
                AOD_ACCEL_Z_LOW: rdata_next = axis_byte(z_reg, 1'b0, byte_order_select_i,
                                                        fast_read_i);
                AOD_ACCEL_Z_HIGH: rdata_next = axis_byte(z_reg, 1'b1, byte_order_select_i,
                                                         fast_read_i);
                default: rdata_next = AOD_BYTE_ZERO;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= AOD_IDLE;
            cnt_reg <= '0;
            temp_hold_reg <= AOD_BYTE_ZERO;
            x_hold_reg <= AOD_WORD_ZERO;
            y_hold_reg <= AOD_WORD_ZERO;
            z_hold_reg <= AOD_WORD_ZERO;
            temp_reg <= AOD_BYTE_ZERO;
            x_reg <= AOD_WORD_ZERO;
            y_reg <= AOD_WORD_ZERO;
            z_reg <= AOD_WORD_ZERO;
            mag_reg <= AOD_WORD_ZERO;
            drdy_reg <= 1'b0;
            ptr_reg <= AOD_BYTE_ZERO;
            rdata_reg <= AOD_BYTE_ZERO;
            ack_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            temp_hold_reg <= temp_hold_next;
            x_hold_reg <= x_hold_next;
            y_hold_reg <= y_hold_next;
            z_hold_reg <= z_hold_next;
            temp_reg <= temp_next;
            x_reg <= x_next;
            y_reg <= y_next;
            z_reg <= z_next;
            mag_reg <= mag_next;
            drdy_reg <= drdy_next;
            ptr_reg <= ptr_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            refused_reg <= refused_next;
        end
    end

    // Outputs
    assign reg_rdata_o = rdata_reg;
    assign reg_ack_o = ack_reg;
    assign reg_refused_o = refused_reg;
    assign data_ready_flag_o = drdy_reg;
endmodule

/* tb/aod_output_regs_sva.sv */
// Port-level assertions for the accelerometer output register block
`timescale 1ns/1ps
module aod_output_regs_sva
    import aod_pkg::*;
#(
    parameter int SPACING_CYC = aod_pkg::AOD_SPACING_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Configuration and trigger
    input wire logic boot_done_i,
    input wire logic magnitude_enable_i,
    input wire logic byte_order_select_i,
    input wire logic fast_read_i,
    input wire logic output_data_rate_tick_i,
    input wire logic [aod_pkg::AOD_TW-1:0] temp_sample_i,
    input wire logic [aod_pkg::AOD_SW-1:0] adc_sample_i,
    // Register port
    input wire logic reg_start_i,
    input wire logic [aod_pkg::AOD_AW-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [aod_pkg::AOD_DW-1:0] reg_wdata_i,
    input wire logic [aod_pkg::AOD_DW-1:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic reg_refused_o,
    input wire logic data_ready_flag_o
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Cycles since the last conversion trigger, saturating
    always_comb begin
        cnt_next = cnt_reg;
        if (output_data_rate_tick_i) begin
            cnt_next = 16'h0000;
        end else if (cnt_reg != 16'hffff) begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 16'hffff;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    // Every request gets exactly one answer one cycle later
    answer_once_a: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o ^ reg_refused_o)
        else $error("request not answered exactly once");
    no_spurious_a: assert property (!(reg_rd_i || reg_wr_i) |=> !reg_ack_o && !reg_refused_o)
        else $error("answer without request");
    early_refuse_a: assert property ((reg_rd_i || reg_wr_i) && !boot_done_i && !$past(boot_done_i)
        && !$past(boot_done_i, 2) |=> reg_refused_o)
        else $error("access accepted before boot");
    boot_accept_a: assert property ((reg_rd_i || reg_wr_i) && $past(boot_done_i) && $past(rst_b_i)
        && $past(boot_done_i, 2) && $past(rst_b_i, 2) |=> reg_ack_o)
        else $error("access refused after boot");
    refuse_no_data_a: assert property (reg_refused_o |-> $stable(reg_rdata_o))
        else $error("refused access moved read data");
    write_no_data_a: assert property (reg_wr_i && !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("write changed read data");
    flag_read_clear_a: assert property ($fell(data_ready_flag_o) |-> reg_ack_o && $past(reg_rd_i))
        else $error("ready flag fell without a read");
    latch_after_z_a: assert property ($rose(data_ready_flag_o) |-> cnt_reg >= 16'(3 * SPACING_CYC)
        && cnt_reg <= 16'(3 * SPACING_CYC + 3))
        else $error("sample latched at wrong time");
    mag_nibble_a: assert property (reg_rd_i && reg_start_i && reg_addr_i == AOD_MAGNITUDE_HIGH
        && !byte_order_select_i |=> !reg_ack_o || reg_rdata_o[7:4] == 4'h0)
        else $error("magnitude high nibble not zero");
    be_low_zero_a: assert property (reg_rd_i && reg_start_i && byte_order_select_i
        && reg_addr_i inside {8'h05, 8'h07, 8'h09} |=> !reg_ack_o || reg_rdata_o[3:0] == 4'h0)
        else $error("big-endian low nibble not zero");
    le_sign_fill_a: assert property (reg_rd_i && reg_start_i && !byte_order_select_i && !fast_read_i
        && reg_addr_i inside {8'h05, 8'h07, 8'h09} |=> !reg_ack_o
        || reg_rdata_o[7:4] == {4{reg_rdata_o[3]}})
        else $error("sign fill wrong");
endmodule
bind aod_output_regs aod_output_regs_sva #(.SPACING_CYC(SPACING_CYC)) u_aod_output_regs_sva (
    .mclk_i, .rst_b_i, .boot_done_i, .magnitude_enable_i, .byte_order_select_i, .fast_read_i,
    .output_data_rate_tick_i, .temp_sample_i, .adc_sample_i, .reg_start_i, .reg_addr_i,
    .reg_rd_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_refused_o,
    .data_ready_flag_o);

/* tb/aod_host_model.sv */
// Host model: issues register bursts and collects the answers
`timescale 1ns/1ps
module aod_host_model (
    // Clock
    input wire logic mclk_i,
    // Answers from the register port
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_ack_i,
    input wire logic reg_refused_i,
    // Requests to the register port
    output logic reg_start_o,
    output logic [7:0] reg_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o
);
    logic [9:0] ans_q[$];
    // Idle request lines at time zero
    initial begin
        reg_start_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // One byte per cycle back to back; answers sampled mid-cycle as {ack, refused, data}
    task automatic burst(input logic [7:0] a, input int n, input logic w);
        for (int i = 0; i <= n; i++) begin
            @(posedge mclk_i);
            reg_start_o <= (i == 0) && (n > 0);
            reg_rd_o <= (i < n) && !w;
            reg_wr_o <= (i < n) && w;
            reg_addr_o <= (i == 0) ? a : ~a;
            reg_wdata_o <= 8'($urandom);
            @(negedge mclk_i);
            if (i > 0) begin
                ans_q.push_back({reg_ack_i, reg_refused_i, reg_rdata_i});
            end
        end
    endtask
    // Big-endian pair to a signed count: drop the four filler bits, keep the sign
    function automatic logic [15:0] be_join(input logic [7:0] hi, input logic [7:0] lo);
        return 16'($signed({hi, lo}) >>> 4);
    endfunction
endmodule

/* tb/aod_output_regs_tb.sv */
// Self-checking bench for the output data register block
`timescale 1ns/1ps
module aod_output_regs_tb;
    import aod_pkg::*;
    localparam int SPC = 4;
    logic mclk_i, rst_b_i, boot_done_i, magnitude_enable_i, byte_order_select_i, fast_read_i;
    logic output_data_rate_tick_i, reg_start_i, reg_rd_i, reg_wr_i, reg_ack_o, reg_refused_o;
    logic data_ready_flag_o;
    logic [7:0] temp_sample_i, reg_addr_i, reg_wdata_i, reg_rdata_o, temp_m;
    logic [11:0] adc_sample_i, mag_m;
    logic [11:0] axis_m[3];
    int err_total = 0;
    int checks_done = 0;
    aod_output_regs #(.SPACING_CYC(SPC)) u_aod_output_regs (.mclk_i, .rst_b_i, .boot_done_i,
        .magnitude_enable_i, .byte_order_select_i, .fast_read_i, .output_data_rate_tick_i,
        .temp_sample_i, .adc_sample_i, .reg_start_i, .reg_addr_i, .reg_rd_i, .reg_wr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_refused_o, .data_ready_flag_o);
    aod_host_model u_aod_host_model (.mclk_i, .reg_rdata_i(reg_rdata_o), .reg_ack_i(reg_ack_o),
        .reg_refused_i(reg_refused_o), .reg_start_o(reg_start_i), .reg_addr_o(reg_addr_i),
        .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
    // Clock, 100 ns period
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    task automatic conclude();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected byte at an address under the present order and fast-read settings
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        logic [11:0] v;
        logic hb;
        v = (a >= 8'h04) ? axis_m[2'((a - 8'h04) >> 1)] : mag_m;
        hb = byte_order_select_i || (fast_read_i && a >= 8'h04);
        if (a == AOD_TEMPERATURE_OUT) return temp_m;
        if (a < 8'h02 || a > 8'h09) return 8'h00;
        if (hb) return a[0] ? {v[3:0], 4'h0} : v[11:4];
        return a[0] ? {(a < 8'h04) ? 4'h0 : {4{v[11]}}, v[11:8]} : v[7:0];
    endfunction
    function automatic logic [7:0] nxt(input logic [7:0] a);
        return (fast_read_i && a inside {8'h04, 8'h06, 8'h08}) ? a + 8'h02 : a + 8'h01;
    endfunction
    function automatic logic [11:0] mag_of();
        int s, r;
        s = 0;
        r = 0;
        for (int k = 0; k < 3; k++) s += $signed(axis_m[k]) * $signed(axis_m[k]);
        while ((r + 1) * (r + 1) <= s) r++;
        return (r > 4095) ? 12'hfff : 12'(r);
    endfunction
    // Burst read compared byte by byte against the model
    task automatic read_chk(input logic [7:0] a, input int n, input logic ok);
        logic [7:0] p;
        p = a;
        u_aod_host_model.burst(a, n, 1'b0);
        repeat (n) begin
            chk(16'(u_aod_host_model.ans_q.pop_front()), ok ? {8'h02, exp_byte(p)} : 16'h0100);
            p = nxt(p);
        end
    endtask
    // One conversion: temperature on the trigger, then X, Y, Z spaced by SPC
    task automatic acquire(input int m);
        temp_m = 8'($urandom);
        for (int k = 0; k < 3; k++) axis_m[k] = 12'($urandom);
        if (m == 0) axis_m[0] = 12'h800;
        if (m == 2) axis_m[1] = 12'h7ff;
        @(posedge mclk_i);
        output_data_rate_tick_i <= 1'b1;
        temp_sample_i <= temp_m;
        adc_sample_i <= axis_m[0];
        @(posedge mclk_i);
        output_data_rate_tick_i <= 1'b0;
        temp_sample_i <= ~temp_m;
        for (int k = 1; k <= 3; k++) begin
            repeat (SPC) @(posedge mclk_i);
            adc_sample_i <= (k < 3) ? axis_m[k] : ~axis_m[2];
        end
        repeat (40) @(negedge mclk_i);
    endtask
    // Hang guard, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        conclude();
    end
    initial begin
        logic [9:0] b0, b1;
        rst_b_i = 1'b0;
        boot_done_i = 1'b0;
        magnitude_enable_i = 1'b1;
        byte_order_select_i = 1'b0;
        fast_read_i = 1'b0;
        output_data_rate_tick_i = 1'b0;
        temp_sample_i = 8'h00;
        adc_sample_i = 12'h000;
        mag_m = 12'h000;
        void'($urandom(32'he06d));
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        read_chk(AOD_ACCEL_X_LOW, 2, 1'b0);
        @(posedge mclk_i);
        boot_done_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        read_chk(AOD_MAGNITUDE_LOW, 2, 1'b1);
        read_chk(8'h0a, 1, 1'b1);
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk_i);
            byte_order_select_i <= (m == 1);
            fast_read_i <= (m == 2);
            magnitude_enable_i <= (m != 3);
            acquire(m);
            if (m != 3) mag_m = mag_of();
            chk({15'h0000, data_ready_flag_o}, 16'h0001);
            if (m == 1 || m == 3) begin
                read_chk((m == 1) ? AOD_MAGNITUDE_HIGH : AOD_ACCEL_Z_HIGH, 1, 1'b1);
                chk({15'h0000, data_ready_flag_o}, 16'h0000);
            end
            read_chk(AOD_TEMPERATURE_OUT, (m == 2) ? 6 : 9, 1'b1);
            chk({15'h0000, data_ready_flag_o}, 16'h0000);
            if (m == 2) read_chk(AOD_MAGNITUDE_HIGH, 1, 1'b1);
            if (m == 1) begin
                u_aod_host_model.burst(AOD_ACCEL_X_LOW, 2, 1'b0);
                b0 = u_aod_host_model.ans_q.pop_front();
                b1 = u_aod_host_model.ans_q.pop_front();
                chk(u_aod_host_model.be_join(b0[7:0], b1[7:0]), {{4{axis_m[0][11]}}, axis_m[0]});
                read_chk(AOD_ACCEL_Y_HIGH, 1, 1'b1);
            end
        end
        u_aod_host_model.burst(AOD_ACCEL_Y_LOW, 2, 1'b1);
        repeat (2) chk(16'(u_aod_host_model.ans_q.pop_front() >> 9), 16'h0001);
        read_chk(AOD_ACCEL_Y_LOW, 2, 1'b1);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        mag_m = 12'h000;
        repeat (3) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        read_chk(AOD_MAGNITUDE_LOW, 2, 1'b1);
        conclude();
    end
endmodule
